// [dbs_axil_slave.sv]
module dbs_axil_slave
	import dbs_pkg::*;
(
	input  wire logic          aclk,    // core clock
	input  wire logic          aresetn, // sync reset, low
	input  wire logic [AW-1:0] awaddr,  // write address
	input  wire logic          awvalid, // write address valid
	output logic               awready, // write address ready
	input  wire logic [31:0]   wdata,   // write data
	input  wire logic [3:0]    wstrb,   // byte enables
	input  wire logic          wvalid,  // write data valid
	output logic               wready,  // write data ready
	output logic [1:0]         bresp,   // write response
	output logic               bvalid,  // write response valid
	input  wire logic          bready,  // write response ready
	input  wire logic [AW-1:0] araddr,  // read address
	input  wire logic          arvalid, // read address valid
	output logic               arready, // read address ready
	output logic [31:0]        rdata,   // read data
	output logic [1:0]         rresp,   // read response
	output logic               rvalid,  // read data valid
	input  wire logic          rready,  // read data ready
	output logic               wr_req,  // one-cycle register write
	output logic [AW-1:0]      wr_addr, // held write address
	output logic [31:0]        wr_data, // held write data
	output logic [3:0]         wr_strb, // held byte enables
	input  wire logic          wr_err,  // write address unmapped
	output logic [AW-1:0]      rd_addr, // read address to decode
	input  wire logic [31:0]   rd_data, // decoded read word
	input  wire logic          rd_err   // read address unmapped
);
	logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]    next_bresp, next_rresp;
	logic [AW-1:0] next_wr_addr;
	logic [31:0]   next_wr_data, next_rdata;
	logic [3:0]    next_wr_strb;

	// address and data held until both are in, then one strobe
	assign wr_req  = !awready && !wready && !bvalid;
	assign rd_addr = araddr;

	// ----------------------------------------
	// channel handshakes
	// ----------------------------------------
	always_comb begin
		next_awready = awready;
		next_wready  = wready;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready) begin
			next_awready = 1'b0;
			next_wr_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_wready  = 1'b0;
			next_wr_data = wdata;
			next_wr_strb = wstrb;
		end
		if (wr_req) begin
			next_bvalid = 1'b1;
			next_bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (bvalid && bready) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rdata   = rd_err ? RST_WORD : rd_data;
			next_rresp   = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (rvalid && rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			wr_addr <= '0;
			wr_data <= RST_WORD;
			wr_strb <= 4'h0;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= RST_WORD;
			rresp   <= RESP_OKAY;
		end else begin
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end
endmodule

// [dbs_barrel_shifter.sv]
module dbs_barrel_shifter
	import dbs_pkg::*;
(
	input  wire logic          aclk,          // core clock, 250 MHz
	input  wire logic          aresetn,       // sync reset, low
	input  wire logic [AW-1:0] s_axi_awaddr,  // write address
	input  wire logic          s_axi_awvalid, // write address valid
	output logic               s_axi_awready, // write address ready
	input  wire logic [31:0]   s_axi_wdata,   // write data
	input  wire logic [3:0]    s_axi_wstrb,   // byte enables
	input  wire logic          s_axi_wvalid,  // write data valid
	output logic               s_axi_wready,  // write data ready
	output logic [1:0]         s_axi_bresp,   // write response
	output logic               s_axi_bvalid,  // write response valid
	input  wire logic          s_axi_bready,  // write response ready
	input  wire logic [AW-1:0] s_axi_araddr,  // read address
	input  wire logic          s_axi_arvalid, // read address valid
	output logic               s_axi_arready, // read address ready
	output logic [31:0]        s_axi_rdata,   // read data
	output logic [1:0]         s_axi_rresp,   // read response
	output logic               s_axi_rvalid,  // read data valid
	input  wire logic          s_axi_rready   // read data ready
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0]   dreg [8];
	logic [31:0]   next_dreg [8];
	logic [39:0]   acc [2];
	logic [39:0]   next_acc [2];
	dbs_flags_t    flags, next_flags;
	dbs_cmd_t      last_cmd, next_last_cmd, cmd;
	dbs_field_t    fld;
	logic          wr_req, wr_err, rd_err, exec;
	logic [AW-1:0] wr_addr, rd_addr;
	logic [31:0]   wr_data, rd_data, src_word, amt_word, res, fmask, dst_old;
	logic [3:0]    wr_strb;
	logic [2:0]    dst_idx;
	logic [32:0]   amt, magn;
	logic [6:0]    mag;
	logic [39:0]   lo_din, lo_out, hi_out;
	logic [5:0]    lo_wb;
	logic          lo_cc, lo_ovf, hi_ovf, tbit, is_acc;
	logic [4:0]    flen;

	// merge a write under its byte enables
	function automatic logic [31:0] dbs_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// redundant sign bits, the exponent of a normalised word
	function automatic logic [15:0] dbs_signbits(input logic [31:0] w);
		logic [15:0] cnt;
		logic        run;
		cnt = 16'h0000;
		run = 1'b1;
		for (int i = 30; i >= 0; i--) begin
			run = run && (w[i] == w[31]);
			if (run)
				cnt = cnt + 16'h0001;
		end
		return cnt;
	endfunction

	// ----------------------------------------
	// bus slave and address decode
	// ----------------------------------------
	dbs_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_req  (wr_req),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// unaligned or past the command word answers slverr
	assign wr_err = (wr_addr[1:0] != 2'h0) || (wr_addr > ADDR_CMD);
	assign rd_err = (rd_addr[1:0] != 2'h0) || (rd_addr > ADDR_CMD);

	always_comb begin
		unique case (rd_addr)
			ADDR_ACC0_LO: rd_data = acc[0][31:0];
			ADDR_ACC0_EX: rd_data = {24'h000000, acc[0][39:32]};
			ADDR_ACC1_LO: rd_data = acc[1][31:0];
			ADDR_ACC1_EX: rd_data = {24'h000000, acc[1][39:32]};
			ADDR_FLAGS:   rd_data = {25'h0000000, flags};
			ADDR_CMD:     rd_data = last_cmd;
			default:      rd_data = (rd_addr < ADDR_ACC0_LO) ? dreg[rd_addr[4:2]] : RST_WORD;
		endcase
	end

	// ----------------------------------------
	// operand fetch
	// ----------------------------------------
	// a write to the command word issues the operation in the same cycle
	assign exec     = wr_req && (wr_addr == ADDR_CMD);
	assign cmd      = dbs_cmd_t'(wr_data);
	assign src_word = dreg[cmd.src];
	assign amt_word = dreg[cmd.areg];
	assign fld      = dbs_field_t'(amt_word);
	assign is_acc   = (cmd.form == FORM_ACC);
	assign tbit     = src_word[cmd.imm[4:0]];
	assign dst_idx  = cmd.two_op ? cmd.src : cmd.dst;
	assign dst_old  = dreg[dst_idx];
	assign flen     = (fld.len > FLEN_MAX) ? FLEN_MAX : fld.len;
	assign fmask    = ~(32'hffff_ffff << flen);

	always_comb begin
		if (!cmd.amt_reg)
			amt = {{27{cmd.imm[5]}}, cmd.imm};
		else if (cmd.two_op)
			amt = {amt_word[31], amt_word};
		else
			amt = {{27{amt_word[5]}}, amt_word[5:0]};
		magn = amt[32] ? 33'(-amt) : amt;
		// anything past 64 is capped at 64, a full flush for every shift lane
		mag  = (magn > {26'h0, MAG_CAP}) ? MAG_CAP : magn[6:0];
	end

	always_comb begin
		unique case (cmd.form)
			FORM_ACC: begin
				lo_din = acc[cmd.acc_sel];
				lo_wb  = WB40;
			end
			FORM_WORD: begin
				lo_din = {8'h00, src_word};
				lo_wb  = WB32;
			end
			default: begin
				lo_din = {24'h000000, src_word[15:0]};
				lo_wb  = WB16;
			end
		endcase
	end

	// ----------------------------------------
	// shifter lanes, high lane only for pairs
	// ----------------------------------------
	// lane selects fill and ring
	dbs_shift_unit u_lo (
		.din    (lo_din),
		.wbits  (lo_wb),
		.rotate_through_flag_op    (cmd.op == OP_ROT),
		.left   (!amt[32]),
		.arith  (cmd.op == OP_ASH),
		.mag    (mag),
		.cc_in  (flags.cc),
		.dout   (lo_out),
		.cc_out (lo_cc),
		.ovf    (lo_ovf)
	);

	dbs_shift_unit u_hi (
		.din    ({24'h000000, src_word[31:16]}),
		.wbits  (WB16),
		.rotate_through_flag_op    (1'b0),
		.left   (!amt[32]),
		.arith  (cmd.op == OP_ASH),
		.mag    (mag),
		.cc_in  (1'b0),
		.dout   (hi_out),
		.cc_out (),
		.ovf    (hi_ovf)
	);

	// ----------------------------------------
	// execute and register writes
	// ----------------------------------------
	always_comb begin
		next_dreg     = dreg;
		next_acc      = acc;
		next_flags    = flags;
		next_last_cmd = last_cmd;
		res           = dst_old;
		if (exec) begin
			next_last_cmd = cmd;
			unique case (cmd.op)
				OP_ASH, OP_LSH: begin
					if (is_acc) begin
						next_acc[cmd.acc_sel] = lo_out;
						next_flags.z = (lo_out == 40'h0);
						next_flags.n = lo_out[39];
						if (cmd.acc_sel)
							next_flags.av1 = lo_ovf;
						else
							next_flags.av0 = lo_ovf;
					end else begin
						if (cmd.form == FORM_PAIR)
							res = {hi_out[15:0], lo_out[15:0]};
						else if (cmd.form == FORM_HALF)
							res = {dst_old[31:16], lo_out[15:0]};
						else
							res = lo_out[31:0];
						next_dreg[dst_idx] = res;
						next_flags.z = (res == 32'h0);
						next_flags.n = (cmd.form == FORM_HALF) ? res[15] : res[31];
						next_flags.v = lo_ovf || ((cmd.form == FORM_PAIR) && hi_ovf);
					end
				end
				OP_ROT: begin
					if (is_acc)
						next_acc[cmd.acc_sel] = lo_out;
					else
						next_dreg[dst_idx] = (cmd.form == FORM_WORD) ? lo_out[31:0]
							: {dst_old[31:16], lo_out[15:0]};
					next_flags.cc = lo_cc;
				end
				OP_BTST: next_flags.cc = tbit;
				OP_BSET, OP_BCLR, OP_BTGL: begin
					res = src_word;
					if (cmd.op == OP_BSET)
						res[cmd.imm[4:0]] = 1'b1;
					else if (cmd.op == OP_BCLR)
						res[cmd.imm[4:0]] = 1'b0;
					else
						res[cmd.imm[4:0]] = !tbit;
					next_dreg[cmd.src] = res;
					next_flags.z = (res == 32'h0);
					next_flags.n = res[31];
					next_flags.c = 1'b0;
					next_flags.v = 1'b0;
				end
				OP_EXTR, OP_DEPO: begin
					if (cmd.op == OP_EXTR)
						res = (src_word >> fld.pos) & fmask;
					else
						res = (src_word & ~(fmask << fld.pos))
							| (({16'h0000, fld.val} & fmask) << fld.pos);
					next_dreg[dst_idx] = res;
					next_flags.z = (res == 32'h0);
					next_flags.n = res[31];
					next_flags.c = 1'b0;
					next_flags.v = 1'b0;
				end
				OP_PACK:  next_dreg[dst_idx] = {src_word[15:0], amt_word[15:0]};
				OP_SIGNB: next_dreg[dst_idx] = {dst_old[31:16], dbs_signbits(src_word)};
				// spare codes do nothing but are remembered
				default: ;
			endcase
		end else if (wr_req && !wr_err) begin
			// plain software access to the register file
			if (wr_addr < ADDR_ACC0_LO)
				next_dreg[wr_addr[4:2]] = dbs_merge(dreg[wr_addr[4:2]], wr_data, wr_strb);
			else if (wr_addr == ADDR_ACC0_LO || wr_addr == ADDR_ACC1_LO)
				next_acc[wr_addr[3]][31:0] = dbs_merge(acc[wr_addr[3]][31:0], wr_data, wr_strb);
			else if (wr_addr == ADDR_ACC0_EX || wr_addr == ADDR_ACC1_EX) begin
				if (wr_strb[0])
					next_acc[wr_addr[3]][39:32] = wr_data[7:0];
			end else if (wr_addr == ADDR_FLAGS && wr_strb[0])
				next_flags = dbs_flags_t'(wr_data[6:0]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++)
				dreg[i] <= RST_WORD;
			acc[0]   <= RST_ACC;
			acc[1]   <= RST_ACC;
			flags    <= dbs_flags_t'(RST_FLAGS);
			last_cmd <= dbs_cmd_t'(RST_WORD);
		end else begin
			dreg     <= next_dreg;
			acc      <= next_acc;
			flags    <= next_flags;
			last_cmd <= next_last_cmd;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_exec(dbs_op_t o);
		exec && (cmd.op == o);
	endsequence
	sequence s_flags_kept;
		$stable(flags.z) && $stable(flags.n) && $stable(flags.c) && $stable(flags.v);
	endsequence

	chk_rot_flags_only: assert property (s_exec(OP_ROT) |=> s_flags_kept)
		else $error("rotate changed an arithmetic flag");
	chk_rot_last_bit: assert property (s_exec(OP_ROT) |=> flags.cc == $past(lo_cc))
		else $error("flag does not hold last rotated bit");
	chk_test_to_flag: assert property (s_exec(OP_BTST) |=> ((flags.cc == $past(tbit)) and s_flags_kept))
		else $error("bit test result missing from flag");
	chk_bitop_flags: assert property ((s_exec(OP_BSET) or s_exec(OP_BCLR) or s_exec(OP_BTGL))
		|=> !flags.c && !flags.v && $stable(flags.cc))
		else $error("bit modify flag update wrong");
	chk_acc_ovf_sel: assert property (s_exec(OP_ASH) ##0 (is_acc && !cmd.acc_sel)
		|=> $stable(flags.av1) && flags.av0 == $past(lo_ovf))
		else $error("wrong accumulator overflow flag");
	chk_big_mag: assert property (s_exec(OP_LSH) ##0 (cmd.two_op && cmd.amt_reg
		&& cmd.form == FORM_WORD && magn >= 33'h20)
		|=> dreg[$past(dst_idx)] == 32'h0)
		else $error("large register shift not flushed");
	chk_extract_hi: assert property (s_exec(OP_EXTR) |=> dreg[$past(dst_idx)][31:16] == 16'h0)
		else $error("extracted field wider than sixteen");
	chk_arith_fill: assert property (s_exec(OP_ASH) ##0 (cmd.form == FORM_WORD && amt[32]
		&& src_word[31]) |=> dreg[$past(dst_idx)][31])
		else $error("arithmetic right shift lost sign");
	chk_resp_bound: assert property (wr_req |=> s_axi_bvalid)
		else $error("write response missing");
endmodule

// [dbs_host.sv]
module dbs_host
	import dbs_pkg::*;
(
	input  wire logic          aclk,    // core clock
	output logic [AW-1:0]      awaddr,  // write address
	output logic               awvalid, // aw valid
	input  wire logic          awready, // aw ready
	output logic [31:0]        wdata,   // write data
	output logic [3:0]         wstrb,   // byte enables
	output logic               wvalid,  // w valid
	input  wire logic          wready,  // w ready
	input  wire logic [1:0]    bresp,   // write response
	input  wire logic          bvalid,  // b valid
	output logic               bready,  // b ready
	output logic [AW-1:0]      araddr,  // read address
	output logic               arvalid, // ar valid
	input  wire logic          arready, // ar ready
	input  wire logic          rvalid,  // r valid
	output logic               rready   // r ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus; payload all ones at start, address and write data inverted after each transfer, so stale values never pass for live ones
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = '1;
	end
	// one write, aw and w each released on its own ready
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		awaddr <= ~a;
		wdata <= ~d;
	endtask
	// one read; data is judged by the bench monitor at the same edge
	task automatic rd(input logic [AW-1:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		araddr <= ~a;
	endtask
endmodule

// [dbs_pkg.sv]
package dbs_pkg;
	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam int         AW           = 8;
	localparam logic [7:0] ADDR_DREG0   = 8'h00;
	localparam logic [7:0] ADDR_ACC0_LO = 8'h20;
	localparam logic [7:0] ADDR_ACC0_EX = 8'h24;
	localparam logic [7:0] ADDR_ACC1_LO = 8'h28;
	localparam logic [7:0] ADDR_ACC1_EX = 8'h2c;
	localparam logic [7:0] ADDR_FLAGS   = 8'h30;
	localparam logic [7:0] ADDR_CMD     = 8'h34;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ----------------------------------------
	// reset values and widths
	// ----------------------------------------
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [39:0] RST_ACC   = 40'h00_0000_0000;
	localparam logic [6:0]  RST_FLAGS = 7'h00;
	localparam logic [5:0]  WB16      = 6'h10;
	localparam logic [5:0]  WB32      = 6'h20;
	localparam logic [5:0]  WB40      = 6'h28;
	localparam logic [6:0]  MAG_CAP   = 7'h40;
	localparam logic [4:0]  FLEN_MAX  = 5'h10;

	// ----------------------------------------
	// operations, forms and carriers
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_ASH, OP_LSH, OP_ROT, OP_BTST, OP_BSET, OP_BCLR,
		OP_BTGL, OP_EXTR, OP_DEPO, OP_PACK, OP_SIGNB
	} dbs_op_t;
	typedef enum logic [1:0] {FORM_HALF, FORM_PAIR, FORM_WORD, FORM_ACC} dbs_form_t;

	typedef struct packed {
		logic [7:0] spare;
		logic       two_op;
		logic       acc_sel;
		logic [2:0] dst;
		logic [2:0] areg;
		logic [2:0] src;
		logic [5:0] imm;
		logic       amt_reg;
		dbs_form_t  form;
		dbs_op_t    op;
	} dbs_cmd_t;

	typedef struct packed {
		logic cc;
		logic av1;
		logic av0;
		logic v;
		logic c;
		logic n;
		logic z;
	} dbs_flags_t;

	typedef struct packed {
		logic [15:0] val;
		logic [2:0]  pad1;
		logic [4:0]  pos;
		logic [2:0]  pad0;
		logic [4:0]  len;
	} dbs_field_t;
endpackage

// [dbs_shift_unit.sv]
module dbs_shift_unit
	import dbs_pkg::*;
(
	input  wire logic [39:0] din,    // operand, right aligned
	input  wire logic [5:0]  wbits,  // lane width 16, 32 or 40
	input  wire logic        rotate_through_flag_op,    // rotate through flag
	input  wire logic        left,   // direction
	input  wire logic        arith,  // sign fill on right shift
	input  wire logic [6:0]  mag,    // capped magnitude
	input  wire logic        cc_in,  // flag entering the ring
	output logic      [39:0] dout,   // result, upper bits zero
	output logic             cc_out, // last bit rotated into flag
	output logic             ovf     // significant bits lost on arithmetic left shift
);
	logic [39:0] mask;
	logic [39:0] sx;
	logic [39:0] raw;
	logic [39:0] sd;
	logic [39:0] back;
	logic [40:0] ext;
	logic [40:0] rmask;
	logic [40:0] rot_v;
	logic [81:0] ring;
	logic [6:0]  wp;
	logic [6:0]  rm;
	logic [6:0]  n;

	// ----------------------------------------
	// shift and rotate datapath
	// ----------------------------------------
	always_comb begin
		mask  = ~(40'hff_ffff_ffff << wbits);
		sx    = din[wbits - 6'h1] ? (din | ~mask) : (din & mask);
		// flag sits below bit 0, ring is one bit wider than the lane
		wp    = {1'b0, wbits} + 7'h01;
		rm    = mag % wp;
		n     = left ? rm : ((rm == 7'h00) ? 7'h00 : wp - rm);
		ext   = {din & mask, cc_in};
		rmask = ~({41{1'b1}} << wp);
		ring  = ({41'h0, ext} << n) | ({41'h0, ext} >> (wp - n));
		rot_v = ring[40:0] & rmask;
		// vacated bits fill with zero, or with sign on arithmetic right
		if (left)
			raw = (din << mag) & mask;
		else if (arith)
			raw = 40'($signed(sx) >>> mag) & mask;
		else
			raw = (din & mask) >> mag;
		sd     = raw[wbits - 6'h1] ? (raw | ~mask) : raw;
		back   = 40'($signed(sd) >>> mag);
		dout   = rotate_through_flag_op ? rot_v[40:1] : raw;
		cc_out = rot_v[0];
		ovf    = !rotate_through_flag_op && left && arith && (back != sx);
	end
endmodule

// [tb.sv]
module tb
	import dbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [AW-1:0] awaddr, araddr;
	logic          awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0]   wdata, rdata, x;
	logic [31:0]   seed = 32'h0000005a;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, br;
	logic [4:0]    k;
	logic [33:0]   e;
	logic [33:0]   exp_q[$];
	int            error_cnt = 0;
	int            num_checks = 0;

	dbs_barrel_shifter i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dbs_host i_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rvalid, .rready);

	initial forever #2 aclk = ~aclk;
	// -------------------------
	// helpers
	// -------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] dr(int n);
		return ADDR_DREG0 + 8'(4 * n);
	endfunction
	function automatic logic [31:0] cmd(dbs_op_t op, dbs_form_t f, logic ar, logic [5:0] im,
		logic [2:0] s, logic [2:0] a, logic [2:0] d, logic two);
		return {8'h00, two, 1'b0, d, a, s, im, ar, f, op};
	endfunction
	task automatic cmp(input string n, input logic [31:0] ev, input logic [31:0] sv);
		num_checks++;
		if (sv !== ev) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, ev, sv);
		end
	endtask
	task automatic w(input logic [AW-1:0] a, input logic [31:0] d);
		i_host.wr(a, d, br);
		cmp("bresp", {30'h0, RESP_OKAY}, {30'h0, br});
	endtask
	// expectation is queued before the request goes out
	task automatic r(input logic [AW-1:0] a, input logic [31:0] ev, input logic [1:0] er = RESP_OKAY);
		exp_q.push_back({er, ev});
		i_host.rd(a);
	endtask
	// operand in reg 0, amount in reg 1, three-operand result in reg 2
	task automatic sh(dbs_op_t op, dbs_form_t f, logic ar, logic [5:0] im, logic two, logic [31:0] s, a, ev);
		w(dr(0), s);
		w(dr(1), a);
		w(ADDR_CMD, cmd(op, f, ar, im, 3'h0, 3'h1, 3'h2, two));
		r(two ? dr(0) : dr(2), ev);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// read results judged at the handshake edge, oldest note first
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			e = exp_q.pop_front();
			cmp("rdata", e[31:0], rdata);
			cmp("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
		end
	end
	// a few hundred cycles expected; far more means a hang
	initial begin
		#40000;
		error_cnt++;
		give_verdict();
	end
	// -------------------------
	// tests
	// -------------------------
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		r(ADDR_FLAGS, 32'h0);
		r(8'h38, 32'h0, RESP_SLVERR);
		i_host.wr(8'h38, 32'h1, br);
		cmp("bresp", {30'h0, RESP_SLVERR}, {30'h0, br});
		$display("test bus done");
		sh(OP_LSH, FORM_WORD, 0, 6'h3c, 1, 32'h0000b6a3, 0, 32'h00000b6a);
		sh(OP_LSH, FORM_WORD, 0, 6'h04, 1, 32'h0000b6a3, 0, 32'h000b6a30);
		sh(OP_ASH, FORM_WORD, 0, 6'h3c, 1, 32'h80000000, 0, 32'hf8000000);
		sh(OP_LSH, FORM_WORD, 0, 6'h3c, 1, 32'h80000000, 0, 32'h08000000);
		sh(OP_LSH, FORM_WORD, 1, 0, 1, 32'h0000b6a3, 32'h20, 0);
		sh(OP_ASH, FORM_WORD, 1, 0, 1, 32'h80000000, 32'hffffffd8, 32'hffffffff);
		sh(OP_LSH, FORM_WORD, 1, 0, 1, 32'h80000000, 32'hffffffff, 32'h40000000);
		sh(OP_ASH, FORM_WORD, 1, 0, 0, 32'h0000b6a3, 32'h00010044, 32'h000b6a30);
		sh(OP_ASH, FORM_PAIR, 0, 6'h3c, 1, 32'h80008000, 0, 32'hf800f800);
		sh(OP_LSH, FORM_HALF, 0, 6'h04, 1, 32'h1234b6a3, 0, 32'h12346a30);
		sh(OP_PACK, FORM_WORD, 0, 0, 0, 32'hffff1234, 32'hffff5678, 32'h12345678);
		sh(OP_SIGNB, FORM_WORD, 0, 0, 0, 32'h00000b6a, 0, 32'h12340013);
		$display("test shifts done");
		w(ADDR_FLAGS, 32'h01);
		sh(OP_ROT, FORM_WORD, 1, 0, 0, 32'hbbcdef12, 32'h4, 32'hbcdef125);
		r(ADDR_FLAGS, 32'h41);
		w(ADDR_FLAGS, 32'h4c);
		w(dr(3), 0);
		w(ADDR_CMD, cmd(OP_BSET, FORM_WORD, 0, 6'h1f, 3'h3, 0, 0, 1));
		r(dr(3), 32'h80000000);
		r(ADDR_FLAGS, 32'h42);
		w(ADDR_CMD, cmd(OP_BCLR, FORM_WORD, 0, 6'h1f, 3'h3, 0, 0, 1));
		r(ADDR_FLAGS, 32'h41);
		w(ADDR_CMD, cmd(OP_BTGL, FORM_WORD, 0, 6'h00, 3'h3, 0, 0, 1));
		r(dr(3), 32'h1);
		for (int i = 0; i < 4; i++) begin
			x = xs();
			k = 5'(xs());
			w(ADDR_FLAGS, 0);
			w(dr(4), x);
			w(ADDR_CMD, cmd(OP_BTST, FORM_WORD, 0, {1'b0, k}, 3'h4, 0, 0, 1));
			r(dr(4), x);
			r(ADDR_FLAGS, {25'h0, x[k], 6'h00});
		end
		$display("test bits done");
		x = xs();
		w(dr(5), x);
		w(dr(6), 32'h00000408);
		w(ADDR_CMD, cmd(OP_EXTR, FORM_WORD, 0, 0, 3'h5, 3'h6, 3'h7, 0));
		r(dr(7), (x >> 4) & 32'hff);
		w(dr(6), 32'h00001010);
		w(ADDR_CMD, cmd(OP_EXTR, FORM_WORD, 0, 0, 3'h5, 3'h6, 3'h7, 0));
		r(dr(7), x >> 16);
		w(dr(6), 32'h00a50808);
		w(ADDR_CMD, cmd(OP_DEPO, FORM_WORD, 0, 0, 3'h5, 3'h6, 3'h7, 0));
		r(dr(7), (x & 32'hffff00ff) | 32'h0000a500);
		$display("test fields done");
		// 40-bit lanes: sign change on arithmetic left sets the written accumulator's overflow
		w(ADDR_FLAGS, 0);
		w(ADDR_ACC0_EX, 32'h40);
		w(ADDR_CMD, cmd(OP_ASH, FORM_ACC, 0, 6'h01, 0, 0, 0, 1));
		r(ADDR_ACC0_EX, 32'h80);
		r(ADDR_FLAGS, 32'h12);
		w(ADDR_ACC1_EX, 32'h40);
		w(ADDR_CMD, cmd(OP_ASH, FORM_ACC, 0, 6'h01, 0, 0, 0, 1) | 32'h0040_0000);
		r(ADDR_ACC1_EX, 32'h80);
		r(ADDR_FLAGS, 32'h32);
		$display("test accumulators done");
		// second reset in mid-run must bring registers back to their reset values
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		r(dr(7), RST_WORD);
		r(ADDR_FLAGS, {25'h0, RST_FLAGS});
		$display("test reset done");
		@(posedge aclk);
		give_verdict();
	end
endmodule
